// File: shared/jog_remote_params.svh
// Constants for the jog and remote speed block
`ifndef JOG_REMOTE_PARAMS_SVH
`define JOG_REMOTE_PARAMS_SVH
// Register byte offsets
`define OFS_JOG_FREQ 8'h00
`define OFS_JOG_RAMP 8'h04
`define OFS_CTRL 8'h08
`define OFS_REF_FREQ 8'h0C
`define OFS_BASE_FREQ 8'h10
`define OFS_MAX_FREQ 8'h14
`define OFS_ACCEL 8'h18
`define OFS_DECEL 8'h1C
`define OFS_SEC_ACCEL 8'h20
`define OFS_SEC_DECEL 8'h24
`define OFS_OUT_FREQ 8'h28
`define OFS_REMOTE 8'h2C
`define OFS_STORED 8'h30
// Control register fields
`define CTRL_RES_BIT 0
`define CTRL_PAT_LSB 1
`define CTRL_OP_LSB 3
`define CTRL_FN_LSB 6
// Reset values; frequency in 0.01 Hz, times in resolution units
`define RST_JOG_FREQ 16'h01F4
`define RST_JOG_RAMP 16'h0005
`define RST_REF_FREQ 16'h1770
`define RST_BASE_FREQ 16'h1770
`define RST_MAX_FREQ 16'h2EE0
`define RST_RAMP 16'h0032
`define NO_SETTING 16'h270F
// Setting codes
`define PAT_S_CURVE_A 2'h1
`define OP_PANEL_EXT 3'h4
`define OP_NO_JOG_A 3'h3
`define OP_NO_JOG_B 3'h6
`define FN_MULTI 2'h0
`define FN_STORE 2'h1
`define FN_CLEAR_ON_STOP 2'h3
// Timing
`define CLK_HZ 50_000_000
`define TICK_US 1000
`define MINUTE_S 60
`define TENTH_US 100_000
`define HUNDREDTH_US 10_000
`endif

// File: shared/jog_remote_pkg.sv
// Types for the jog and remote speed block
package jog_remote_pkg;
  typedef enum logic [0:0] {NV_BOOT, NV_RUN} nv_state_t;
  typedef logic [15:0] freq_t;
endpackage : jog_remote_pkg

// File: rtl/jog_remote_speed.sv
// Jog and remote set-point frequency logic with APB registers
// How it works
// RQ1: Jog runs at the jog frequency, 5 Hz
// RQ2: One jog ramp time, 0.5 s, both ways
// RQ3: Resolution 0: 0.1 s steps, 1: 0.01 s
// RQ4: Panel jog runs only while run held
// RQ5: S-curve A ramps against base frequency
// RQ6: Second ramp select ignored during jog
// RQ7: Mode 4: keys start, stop key stops; start inputs also run in mode 4, and the stop key does not stop them
// RQ8: Panel jog disabled in modes 3, 6
// RQ9: Function 0 multi-speed, 1 store, 2 no store
// RQ10: Function 3 clears set point when stopped
// RQ11: High raises, middle lowers, low clears
// RQ12: Remote amount adds to external command
// RQ13: Stored set point restored after power-up
// RQ14: Store set point when start turns off
// RQ15: Store each idle minute if value changed
// RQ16: Amount held within zero and maximum
// RQ17: Remote ramp uses second or longer times
// RQ18: Raise and lower work while stopped
// RQ19: Operator avoids storing under frequent changes
// RQ20: Remote ignored during jog or process control
// RQ21: Early power loss keeps older stored value
// RQ22: Late power loss keeps cleared value
// RQ23: Step rate is reference over ramp time
`include "jog_remote_params.svh"
module jog_remote_speed #(
  parameter int TICK_CYC = (`CLK_HZ / 1_000_000) * `TICK_US,
  parameter int MINUTE_TICKS = (`MINUTE_S * 1_000_000) / `TICK_US
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic high_contact_input_i,
  input wire logic middle_contact_input_i,
  input wire logic low_contact_input_i,
  input wire logic forward_start_input_i,
  input wire logic reverse_start_input_i,
  input wire logic second_function_select_input_i,
  input wire logic panel_jog_select_i,
  input wire logic run_key_i,
  input wire logic forward_key_i,
  input wire logic reverse_key_i,
  input wire logic stop_key_i,
  input wire logic process_control_active_i,
  input wire jog_remote_pkg::freq_t ext_freq_i,
  input wire jog_remote_pkg::freq_t nv_data_i,
  output logic nv_write_o,
  output jog_remote_pkg::freq_t nv_data_o,
  output logic [16:0] run_freq_o,
  output logic run_o,
  output logic second_ramp_sel_o,
  output logic multi_speed_en_o
);
  import jog_remote_pkg::*;

  localparam int TENTH_TICKS = `TENTH_US / `TICK_US;
  localparam int HUNDREDTH_TICKS = `HUNDREDTH_US / `TICK_US;

  freq_t jog_freq_r, jog_ramp_r, ref_r, base_r, max_r;
  freq_t accel_r, decel_r, sec_accel_r, sec_decel_r;
  logic res_r;
  logic [1:0] pat_r, fn_r;
  logic [2:0] op_r;
  freq_t jog_out_r, remote_r, stored_r;
  nv_state_t nv_state_r;
  logic run_latch_r, start_any_d_r, raise_d_r, lower_d_r;
  logic [10:0] pin_meta_r, pin_sync_r;
  logic [31:0] tick_cnt_r, min_cnt_r;
  logic tick_r, minute_r;

  // Contact and key pins cross in through two flops
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pin_meta_r <= 11'h000;
      pin_sync_r <= 11'h000;
    end else begin
      pin_meta_r <= {high_contact_input_i, middle_contact_input_i, low_contact_input_i,
                     forward_start_input_i, reverse_start_input_i,
                     second_function_select_input_i, panel_jog_select_i, run_key_i,
                     forward_key_i, reverse_key_i, stop_key_i};
      pin_sync_r <= pin_meta_r;
    end
  end

  logic raise_s, lower_s, clear_s, start_f_s, start_r_s, second_sel_s;
  logic jsel_s, run_s, fkey_s, rkey_s, stop_s;
  assign {raise_s, lower_s, clear_s, start_f_s, start_r_s, second_sel_s, jsel_s, run_s, fkey_s,
          rkey_s, stop_s} = pin_sync_r;

  // Control tick and minute timer
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || tick_cnt_r == 32'(TICK_CYC - 1)) begin
      tick_cnt_r <= 32'h0000_0000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    tick_r <= !rst_i && tick_cnt_r == 32'(TICK_CYC - 1);
  end

  // RQ15 idle minute count
  // Only raise and lower edges restart it; clear has no say
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || raise_s != raise_d_r || lower_s != lower_d_r) begin
      min_cnt_r <= 32'h0000_0000;
      minute_r <= 1'b0;
    end else if (tick_r) begin
      minute_r <= min_cnt_r == 32'(MINUTE_TICKS - 1);
      min_cnt_r <= (min_cnt_r == 32'(MINUTE_TICKS - 1)) ? 32'h0000_0000
                                                        : min_cnt_r + 32'h0000_0001;
    end else begin
      minute_r <= 1'b0;
    end
  end

  // RQ8 panel jog gated by mode
  logic jog_allowed, jog_active, jog_busy, remote_en, remote_live;
  assign jog_allowed = op_r != `OP_NO_JOG_A && op_r != `OP_NO_JOG_B;
  // RQ4 jog only while run key held
  assign jog_active = jsel_s && jog_allowed && run_s;
  assign jog_busy = jog_active || jog_out_r != 16'h0000;
  // RQ9 function select enables remote
  assign remote_en = fn_r != `FN_MULTI;
  // RQ20 remote frozen during jog or control
  assign remote_live = remote_en && !jog_busy && !process_control_active_i &&
                       nv_state_r == NV_RUN;

  // RQ7 panel keys start and stop in mode 4
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || op_r != `OP_PANEL_EXT || stop_s) begin
      run_latch_r <= 1'b0;
    end else if (run_s || fkey_s || rkey_s) begin
      run_latch_r <= 1'b1;
    end
  end
  logic start_any;
  assign start_any = (op_r == `OP_PANEL_EXT) ? (run_latch_r || start_f_s || start_r_s) :
                     (start_f_s || start_r_s);

  // RQ3 time units to ticks
  logic [23:0] unit_ticks;
  assign unit_ticks = res_r ? 24'(HUNDREDTH_TICKS) : 24'(TENTH_TICKS);

  // RQ17 remote ramp choice
  freq_t sec_dn, up_time, dn_time;
  assign sec_dn = (sec_decel_r == `NO_SETTING) ? sec_accel_r : sec_decel_r;
  assign up_time = (second_sel_s || sec_accel_r >= accel_r) ? sec_accel_r : accel_r;
  assign dn_time = (second_sel_s || sec_dn >= decel_r) ? sec_dn : decel_r;

  logic [1:0] ch_active, ch_step, ch_jump;
  logic [23:0] ch_ticks [2];
  freq_t ch_ref [2];
  freq_t jog_target;
  logic raise_req, lower_req;
  assign jog_target = jog_active ? jog_freq_r : 16'h0000;
  assign raise_req = remote_live && raise_s && !lower_s && remote_r < max_r;
  assign lower_req = remote_live && lower_s && !raise_s && remote_r != 16'h0000;
  assign ch_active = {raise_req || lower_req, jog_out_r != jog_target};
  // RQ2 jog ramp time shared both ways
  assign ch_ticks[0] = 24'(jog_ramp_r) * unit_ticks;
  assign ch_ticks[1] = 24'(raise_s ? up_time : dn_time) * unit_ticks;
  // RQ5 S-curve A ramps against base
  assign ch_ref[0] = (pat_r == `PAT_S_CURVE_A) ? base_r : ref_r;
  assign ch_ref[1] = ref_r;

  // RQ23 rate accumulators
  for (genvar c = 0; c < 2; c++) begin : g_ramp
    logic [23:0] acc_r;
    always_ff @(posedge sys_clk_i) begin
      if (rst_i || !ch_active[c]) begin
        acc_r <= 24'h00_0000;
      end else if (tick_r) begin
        acc_r <= acc_r + 24'(ch_ref[c]);
      end else if (ch_step[c]) begin
        acc_r <= acc_r - ch_ticks[c];
      end
    end
    assign ch_step[c] = ch_active[c] && !tick_r && ch_ticks[c] != 24'h00_0000 &&
                        acc_r >= ch_ticks[c];
    assign ch_jump[c] = ch_active[c] && ch_ticks[c] == 24'h00_0000;
  end

  // RQ1 jog output ramps to jog frequency
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || ch_jump[0]) begin
      jog_out_r <= rst_i ? 16'h0000 : jog_target;
    end else if (ch_step[0]) begin
      jog_out_r <= (jog_out_r < jog_target) ? jog_out_r + 16'h0001 : jog_out_r - 16'h0001;
    end
  end

  // Boot waits for software to choose a remote mode
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      nv_state_r <= NV_BOOT;
    end else begin
      case (nv_state_r)
        NV_BOOT: if (remote_en) nv_state_r <= NV_RUN;
        NV_RUN: nv_state_r <= NV_RUN;
        default: nv_state_r <= NV_BOOT;
      endcase
    end
  end

  // RQ11 raise, lower and clear contacts
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      remote_r <= 16'h0000;
    end else if (nv_state_r == NV_BOOT) begin
      // RQ13 restore stored set point
      remote_r <= (fn_r == `FN_STORE) ? nv_data_i : 16'h0000;
    end else if (!remote_live) begin
      remote_r <= remote_r;
    // RQ10 clear as start turns off
    // Edge, not level, so raise still works while stopped
    end else if (clear_s || (fn_r == `FN_CLEAR_ON_STOP && start_any_d_r && !start_any)) begin
      remote_r <= 16'h0000;
    // RQ16 keep within maximum
    end else if (remote_r > max_r) begin
      remote_r <= max_r;
    // RQ18 steps regardless of start state
    end else if (ch_jump[1]) begin
      remote_r <= raise_req ? max_r : 16'h0000;
    end else if (ch_step[1]) begin
      remote_r <= raise_req ? remote_r + 16'h0001 : remote_r - 16'h0001;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      start_any_d_r <= 1'b0;
      raise_d_r <= 1'b0;
      lower_d_r <= 1'b0;
    end else begin
      start_any_d_r <= start_any;
      raise_d_r <= raise_s;
      lower_d_r <= lower_s;
    end
  end

  // RQ14 store on start falling edge
  // RQ15 store on idle minute if changed
  // RQ22 cleared value saved at the next idle minute
  logic store_now;
  assign store_now = fn_r == `FN_STORE && nv_state_r == NV_RUN &&
                     ((start_any_d_r && !start_any) || (minute_r && remote_r != stored_r));
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      nv_write_o <= 1'b0;
      nv_data_o <= 16'h0000;
    end else begin
      nv_write_o <= store_now;
      if (store_now) nv_data_o <= remote_r;
    end
  end
  // RQ21 stored copy loads the boot value, then tracks the last write
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      stored_r <= 16'h0000;
    end else if (nv_state_r == NV_BOOT) begin
      stored_r <= nv_data_i;
    end else if (store_now) begin
      stored_r <= remote_r;
    end
  end

  // RQ12 running frequency sum
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      run_freq_o <= 17'h0_0000;
      run_o <= 1'b0;
      second_ramp_sel_o <= 1'b0;
      multi_speed_en_o <= 1'b1;
    end else begin
      run_freq_o <= jog_busy ? {1'b0, jog_out_r} :
                    remote_live ? {1'b0, ext_freq_i} + {1'b0, remote_r} : {1'b0, ext_freq_i};
      run_o <= jog_busy || start_any;
      // RQ6 second ramps blocked in jog
      second_ramp_sel_o <= second_sel_s && !jog_busy;
      multi_speed_en_o <= !remote_en;
    end
  end

  // APB slave with no wait states
  logic setup, wr_en, hit;
  logic [31:0] rd_val;
  assign setup = psel_i && !penable_i;
  assign wr_en = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;
  always_comb begin
    hit = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr_i)
      `OFS_JOG_FREQ: rd_val = {16'h0000, jog_freq_r};
      `OFS_JOG_RAMP: rd_val = {16'h0000, jog_ramp_r};
      `OFS_CTRL: rd_val = {24'h00_0000, fn_r, op_r, pat_r, res_r};
      `OFS_REF_FREQ: rd_val = {16'h0000, ref_r};
      `OFS_BASE_FREQ: rd_val = {16'h0000, base_r};
      `OFS_MAX_FREQ: rd_val = {16'h0000, max_r};
      `OFS_ACCEL: rd_val = {16'h0000, accel_r};
      `OFS_DECEL: rd_val = {16'h0000, decel_r};
      `OFS_SEC_ACCEL: rd_val = {16'h0000, sec_accel_r};
      `OFS_SEC_DECEL: rd_val = {16'h0000, sec_decel_r};
      `OFS_OUT_FREQ: rd_val = {15'h0000, run_freq_o};
      `OFS_REMOTE: rd_val = {16'h0000, remote_r};
      `OFS_STORED: rd_val = {16'h0000, stored_r};
      default: hit = 1'b0;
    endcase
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= setup;
      pslverr_o <= setup && !hit;
      if (setup) prdata_o <= pwrite_i ? 32'h0000_0000 : rd_val;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      jog_freq_r <= `RST_JOG_FREQ;
      jog_ramp_r <= `RST_JOG_RAMP;
      {fn_r, op_r, pat_r, res_r} <= 8'h00;
      ref_r <= `RST_REF_FREQ;
      base_r <= `RST_BASE_FREQ;
      max_r <= `RST_MAX_FREQ;
      accel_r <= `RST_RAMP;
      decel_r <= `RST_RAMP;
      sec_accel_r <= `RST_RAMP;
      sec_decel_r <= `NO_SETTING;
    end else if (wr_en) begin
      case (paddr_i)
        `OFS_JOG_FREQ: jog_freq_r <= pwdata_i[15:0];
        `OFS_JOG_RAMP: jog_ramp_r <= pwdata_i[15:0];
        `OFS_CTRL: {fn_r, op_r, pat_r, res_r} <= pwdata_i[7:0];
        `OFS_REF_FREQ: ref_r <= pwdata_i[15:0];
        `OFS_BASE_FREQ: base_r <= pwdata_i[15:0];
        `OFS_MAX_FREQ: max_r <= pwdata_i[15:0];
        `OFS_ACCEL: accel_r <= pwdata_i[15:0];
        `OFS_DECEL: decel_r <= pwdata_i[15:0];
        `OFS_SEC_ACCEL: sec_accel_r <= pwdata_i[15:0];
        `OFS_SEC_DECEL: sec_decel_r <= pwdata_i[15:0];
        default: jog_freq_r <= jog_freq_r;
      endcase
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_start_fall;
    start_any_d_r && !start_any ##0 fn_r == `FN_STORE && nv_state_r == NV_RUN;
  endsequence
  sequence s_jog_settled;
    jog_active && jog_out_r == jog_freq_r ##1 jog_active;
  endsequence

  jog_freq_out_a: assert property (s_jog_settled |=> run_freq_o == {1'b0, jog_freq_r}) // RQ1
    else $error("Jog output not at jog frequency");
  jog_step_one_a: assert property (ch_step[0] |=> // RQ2
                                   jog_out_r == $past(jog_out_r) + 16'h0001 ||
                                   jog_out_r == $past(jog_out_r) - 16'h0001)
    else $error("Jog ramp step not one unit");
  jog_release_a: assert property (jog_busy && !run_s && ch_step[0] |=> // RQ4
                                  jog_out_r == $past(jog_out_r) - 16'h0001)
    else $error("Jog did not slow after release");
  jog_mode_block_a: assert property ((op_r == `OP_NO_JOG_A || op_r == `OP_NO_JOG_B) // RQ8
                                     |-> !jog_active)
    else $error("Jog active in blocked mode");
  stop_key_a: assert property (op_r == `OP_PANEL_EXT && stop_s |=> !run_latch_r) // RQ7
    else $error("Stop key did not stop");
  stop_clear_a: assert property (remote_live && fn_r == `FN_CLEAR_ON_STOP && start_any_d_r // RQ10
                                 && !start_any |=> remote_r == 16'h0000)
    else $error("Set point not cleared when stopped");
  store_on_stop_a: assert property (s_start_fall |=> nv_write_o && nv_data_o == $past(remote_r)) // RQ14
    else $error("No store on start off");
  remote_limit_a: assert property (remote_r > max_r && remote_live |=> remote_r <= $past(max_r)) // RQ16
    else $error("Remote amount above maximum");
  remote_freeze_a: assert property (nv_state_r == NV_RUN && jog_busy |=> $stable(remote_r)) // RQ20
    else $error("Remote changed during jog");
  sec_ramp_a: assert property (jog_busy |=> !second_ramp_sel_o) // RQ6
    else $error("Second ramp selected in jog");
endmodule : jog_remote_speed

// File: testbench/switch_panel_model.sv
// Contact switches and operator keypad in front of the block
module switch_panel_model (
  input wire logic sys_clk_i,
  input wire logic [10:0] press_i,
  output logic [10:0] pins_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    pins_o = '0;
  end
  // Clean contacts, no bounce; they change just after an edge
  always @(posedge sys_clk_i) begin
    pins_o <= press_i;
  end
endmodule : switch_panel_model

// File: testbench/jog_and_remote_speed_setting_tb.sv
// Self-checking bench for the jog and remote speed block
`include "jog_remote_params.svh"
module jog_and_remote_speed_setting_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import jog_remote_pkg::*;
  localparam int HI = 10, MI = 9, LO = 8, FS = 7, RS = 6, SF = 5;
  localparam int PJ = 4, RK = 3, FK = 2, RV = 1, SK = 0;
  logic sys_clk_i, rst_i, psel, penable, pwrite, pready, pslverr, perr;
  logic nv_write, run, sec_sel, multi_en, pc_active;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [10:0] press, pins;
  freq_t ext_freq, nv_mem, nv_data;
  logic [16:0] run_freq;
  int mismatches, comparisons;

  switch_panel_model panel (.sys_clk_i(sys_clk_i), .press_i(press), .pins_o(pins));
  jog_remote_speed #(.TICK_CYC(10), .MINUTE_TICKS(20)) uut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .high_contact_input_i(pins[HI]),
    .middle_contact_input_i(pins[MI]), .low_contact_input_i(pins[LO]),
    .forward_start_input_i(pins[FS]), .reverse_start_input_i(pins[RS]),
    .second_function_select_input_i(pins[SF]), .panel_jog_select_i(pins[PJ]),
    .run_key_i(pins[RK]), .forward_key_i(pins[FK]), .reverse_key_i(pins[RV]),
    .stop_key_i(pins[SK]), .process_control_active_i(pc_active), .ext_freq_i(ext_freq),
    .nv_data_i(nv_mem), .nv_write_o(nv_write), .nv_data_o(nv_data), .run_freq_o(run_freq),
    .run_o(run), .second_ramp_sel_o(sec_sel), .multi_speed_en_o(multi_en));

  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  // Nonvolatile store; survives the resets that stand for power cycles
  always @(posedge sys_clk_i) begin
    if (nv_write === 1'b1) begin
      nv_mem <= nv_data;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : cyc
  // One APB transfer; held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    @(posedge sys_clk_i);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge sys_clk_i);
    end
    if (n == 50) begin
      mismatches++;
      $display("Error apb pready expected 1 seen 0");
    end
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(what, rdat, exp);
  endtask : rchk
  task automatic hold(input int b, input int n);
    press[b] <= 1'b1;
    cyc(n);
    press[b] <= 1'b0;
    cyc(6);
  endtask : hold
  task automatic do_reset;
    rst_i <= 1'b1;
    cyc(20);
    rst_i <= 1'b0;
  endtask : do_reset
  // Short ramps (0.1 s), 8 Hz reference, 1 Hz maximum
  // Reference kept low: the short test tick allows only nine steps per tick
  task automatic cfg(input logic [31:0] ctrl);
    apb(1'b1, `OFS_REF_FREQ, 32'h0000_0320);
    apb(1'b1, `OFS_ACCEL, 32'h0000_0001);
    apb(1'b1, `OFS_DECEL, 32'h0000_0001);
    apb(1'b1, `OFS_SEC_ACCEL, 32'h0000_0001);
    apb(1'b1, `OFS_MAX_FREQ, 32'h0000_0064);
    apb(1'b1, `OFS_CTRL, ctrl);
  endtask : cfg
  task automatic wait_nv(input int limit);
    int n;
    n = 0;
    while (nv_write !== 1'b1 && n < limit) begin
      n++;
      @(posedge sys_clk_i);
    end
    check("nv write pulse", 32'(nv_write), 32'h0000_0001);
  endtask : wait_nv

  task automatic t_regs;
    rchk("jog freq", 8'h00, 32'h0000_01F4);
    rchk("jog ramp", 8'h04, 32'h0000_0005);
    rchk("ctrl", `OFS_CTRL, 32'h0000_0000);
    rchk("sec decel", `OFS_SEC_DECEL, `NO_SETTING);
    check("multi speed", 32'(multi_en), 32'h0000_0001);
    apb(1'b1, 8'h40, 32'h0000_1234);
    check("unmapped err", 32'(perr), 32'h0000_0001);
    apb(1'b1, `OFS_REMOTE, 32'h0000_0005);
    check("ro err", 32'(perr), 32'h0000_0000);
    rchk("ro remote", `OFS_REMOTE, 32'h0000_0000);
  endtask : t_regs
  task automatic t_remote;
    cfg(32'h0000_0080);
    cyc(5);
    check("multi off", 32'(multi_en), 32'h0000_0000);
    hold(HI, 160);
    rchk("raise stopped", `OFS_REMOTE, 32'h0000_0064);
    hold(MI, 160);
    rchk("lower floor", `OFS_REMOTE, 32'h0000_0000);
    hold(HI, 160);
    hold(LO, 5);
    rchk("clear", `OFS_REMOTE, 32'h0000_0000);
    pc_active <= 1'b1;
    hold(HI, 100);
    rchk("process ctrl", `OFS_REMOTE, 32'h0000_0000);
    pc_active <= 1'b0;
  endtask : t_remote
  task automatic t_mode4;
    cfg(32'h0000_00A0);
    ext_freq <= 16'h03E8;
    hold(HI, 160);
    hold(FK, 5);
    check("key start", 32'(run), 32'h0000_0001);
    cyc(400);
    check("sum freq", 32'(run_freq), 32'h0000_044C);
    hold(SK, 5);
    check("key stop", 32'(run), 32'h0000_0000);
    cfg(32'h0000_00C0);
    hold(HI, 160);
    rchk("fn3 held", `OFS_REMOTE, 32'h0000_0064);
    hold(FS, 20);
    rchk("fn3 cleared", `OFS_REMOTE, 32'h0000_0000);
  endtask : t_mode4
  task automatic t_store;
    do_reset();
    cfg(32'h0000_0040);
    press[FS] <= 1'b1;
    hold(HI, 160);
    press[FS] <= 1'b0;
    wait_nv(30);
    check("stop store", 32'(nv_data), 32'h0000_0064);
    hold(LO, 5);
    do_reset();
    cfg(32'h0000_0040);
    rchk("early restore", `OFS_REMOTE, 32'h0000_0064);
    hold(LO, 5);
    wait_nv(700);
    check("minute store", 32'(nv_data), 32'h0000_0000);
    do_reset();
    cfg(32'h0000_0040);
    rchk("late restore", `OFS_REMOTE, 32'h0000_0000);
  endtask : t_store
  task automatic t_jog;
    // S-curve A ramps against base; a tiny reference would crawl
    apb(1'b1, `OFS_JOG_FREQ, 32'h0000_0032);
    apb(1'b1, `OFS_REF_FREQ, 32'h0000_0001);
    apb(1'b1, `OFS_BASE_FREQ, 32'h0000_0190);
    for (int r = 0; r < 2; r++) begin
      apb(1'b1, `OFS_CTRL, 32'(r + 2));
      press[PJ] <= 1'b1;
      press[SF] <= 1'b1;
      press[RK] <= 1'b1;
      cyc(100);
      // Same 0.5 s setting, ten times faster at the fine resolution
      check("jog ramping", 32'(run_freq < 17'h0_0032), 32'(r == 0));
      cyc(700);
      check("jog freq", 32'(run_freq), 32'h0000_0032);
      check("jog no second", 32'(sec_sel), 32'h0000_0000);
      press[RK] <= 1'b0;
      cyc(700);
      check("jog release", 32'(run), 32'h0000_0000);
      check("second back", 32'(sec_sel), 32'h0000_0001);
      press <= '0;
      cyc(6);
    end
    for (int m = 3; m < 7; m += 3) begin
      apb(1'b1, `OFS_CTRL, 32'(m << 3));
      press[PJ] <= 1'b1;
      press[RK] <= 1'b1;
      cyc(20);
      check("jog barred", 32'(run), 32'h0000_0000);
      press <= '0;
      cyc(6);
    end
  endtask : t_jog

  task automatic summarize;
    $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  initial begin
    cyc(30000);
    mismatches++;
    $display("Error watchdog expired");
    summarize();
  end
  initial begin
    rst_i = 1'b1;
    {psel, penable, pwrite, pc_active} = '0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    press = '0;
    ext_freq = 16'h0000;
    nv_mem = 16'h0000;
    mismatches = 0;
    comparisons = 0;
    do_reset();
    t_regs();
    t_remote();
    t_mode4();
    t_store();
    t_jog();
    summarize();
  end
endmodule : jog_and_remote_speed_setting_tb
